//--- plic_pkg.sv
// Purpose: Shared constants, types and register map of the level control
// Assumes: APB slave with 32-bit data, registers of up to 16 bits in the low bits, identify flags in bits 30 and 31
// Notes: All offsets are byte addresses of aligned words
package plic_pkg;
  // ****************************************************************
  // Widths and level numbers
  // ****************************************************************
  localparam int LVL_W = 4;
  localparam int WORD_W = 16;
  localparam int CODE_W = 4;
  localparam int VEC_W = 11;
  localparam int NUM_VEC_LEVELS = 4;
  localparam logic [LVL_W-1:0] LVL_ZERO = 4'h0;
  localparam logic [LVL_W-1:0] LVL_INTERNAL = 4'hE;
  localparam logic [LVL_W-1:0] LVL_VEC_LO = 4'hA;
  localparam logic [LVL_W-1:0] LVL_VEC_HI = 4'hD;
  localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
  localparam logic [CODE_W-1:0] CODE_ZERO = 4'h0;
  localparam logic [VEC_W-1:0] VEC_ZERO = 11'h000;
  localparam logic [10:0] IIE_MASK = 11'h7FF;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] OFF_DETECT = 8'h00;
  localparam logic [7:0] OFF_ENABLE = 8'h04;
  localparam logic [7:0] OFF_SRC_EN = 8'h08;
  localparam logic [7:0] OFF_CAUSE = 8'h0C;
  localparam logic [7:0] OFF_CUR = 8'h10;
  localparam logic [7:0] OFF_ACTIVE = 8'h14;
  localparam logic [7:0] OFF_PREV = 8'h18;
  localparam logic [7:0] OFF_PSTAT = 8'h1C;
  localparam logic [7:0] OFF_PADDR = 8'h20;
  localparam logic [7:0] OFF_OP = 8'h24;
  localparam logic [7:0] OFF_IDENT = 8'h28;
  localparam logic [7:0] OFF_ISTAT = 8'h2C;
  localparam logic [7:0] OFF_IMASK = 8'h30;
  localparam logic [7:0] OFF_ACC = 8'h34;

  // ****************************************************************
  // Operation codes written to the operation register
  // ****************************************************************
  localparam logic [3:0] OP_COPY = 4'h1;
  localparam logic [3:0] OP_SET = 4'h2;
  localparam logic [3:0] OP_CLR = 4'h3;
  localparam logic [3:0] OP_GIVEUP = 4'h4;
  localparam logic [3:0] OP_ON = 4'h5;
  localparam logic [3:0] OP_OFF = 4'h6;
  localparam int OP_TGT_BIT = 4;
  localparam int IDENT_GO_BIT = 31;

  // Interrupt status bit positions
  localparam int EV_SWITCH = 0;
  localparam int EV_IDENT = 1;
  localparam int EV_NOANS = 2;
  localparam int EV_W = 3;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic req;
    logic [1:0] level;
  } plic_ident_req_t;

  typedef struct packed {
    logic done;
    logic found;
    logic [VEC_W-1:0] code;
  } plic_ident_rsp_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ASK = 3'b010,
    ST_WAIT = 3'b100
  } plic_ident_st_t;
endpackage

//--- plic_prio.sv
// Purpose: Highest-set-bit encoder with a registered result
// Assumes: One clock, asynchronous active-low reset
// Notes: Result lags the inputs by one cycle
module plic_prio #(
  parameter int N = 16
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pending and enabled bits
  input wire logic [N-1:0] pend,
  // Registered highest set index
  output logic [$clog2(N)-1:0] top_q
);
  import plic_pkg::*;

  // ****************************************************************
  // Encoder
  // ****************************************************************
  logic [$clog2(N)-1:0] top_d; // Combinational result

  // Lowest first so the highest set bit overwrites
  always_comb begin
    top_d = '0;
    for (int i = 0; i < N; i++) begin
      if (pend[i]) begin
        top_d = i[$clog2(N)-1:0];
      end
    end
  end

  // Register the result
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      top_q <= '0;
    end else begin
      top_q <= top_d;
    end
  end
endmodule

//--- plic_top.sv
// Purpose: Program-level priority interrupt control behind an APB slave
// Assumes: Single clock pclk, bus devices answer identify on pins
// Notes: Zero wait-state APB, pready always high
//
// Local design decisions: register access over APB and the placing of the registers.
module plic_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Vectored requests from bus devices, levels 10 to 13
  input wire logic [plic_pkg::NUM_VEC_LEVELS-1:0] vec_req,
  // Internal cause event with its code
  input wire logic cause_valid,
  input wire logic [plic_pkg::CODE_W-1:0] cause_code,
  // Parity fault capture from memory
  input wire logic parity_valid,
  input wire logic [plic_pkg::WORD_W-1:0] parity_status,
  input wire logic [plic_pkg::WORD_W-1:0] parity_addr,
  // Identify search toward bus devices
  output plic_pkg::plic_ident_req_t ident_req,
  input wire plic_pkg::plic_ident_rsp_t ident_rsp,
  // Level state outputs
  output logic [plic_pkg::LVL_W-1:0] current_level,
  output logic level_switch,
  // Interrupt
  output logic irq
);
  import plic_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  logic [WORD_W-1:0] level_detect_bits_q; // Pending levels
  logic [WORD_W-1:0] level_enable_bits_q; // Enabled levels
  logic [10:0] internal_source_enable_q; // Internal sources
  logic [CODE_W-1:0] internal_cause_code_q; // Latest internal cause
  logic [LVL_W-1:0] current_level_q; // Running level
  logic [LVL_W-1:0] previous_level_q; // Level before last change
  logic [WORD_W-1:0] parity_fault_status_q; // Parity status
  logic [WORD_W-1:0] parity_fault_address_q; // Parity address
  logic [WORD_W-1:0] acc_q; // Accumulator operand
  logic switching_on_q; // Level switching enabled
  logic locked_q; // Parity status and address registers locked
  logic [1:0] unlock_seen_q; // Cause read, parity read
  logic [EV_W-1:0] istat_q; // Sticky events
  logic [EV_W-1:0] imask_q; // Event mask
  logic [VEC_W-1:0] ident_code_q; // Last identify code
  logic ident_found_q; // Last identify found a device
  logic level_switch_q; // One-cycle switch pulse
  logic [31:0] prdata_q; // Read data register
  plic_ident_st_t ident_st_q; // Identify search state
  plic_ident_req_t ident_req_q; // Request to bus
  logic [3:0] computed_active_level; // Highest pending enabled level

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic wr_en; // Write access phase
  logic rd_en; // Read access phase
  logic [3:0] op_code; // Operation selector
  logic op_tgt; // Zero detect, one enable
  logic [EV_W-1:0] ev_set; // Events this cycle
  logic [WORD_W-1:0] mask_d; // Enabled and pending

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign op_code = pwdata[3:0];
  assign op_tgt = pwdata[OP_TGT_BIT];
  assign mask_d = level_detect_bits_q & level_enable_bits_q;

  // Applies a masked or copy operation to one word
  function automatic logic [WORD_W-1:0] apply_op(
    input logic [3:0] op,
    input logic [WORD_W-1:0] cur,
    input logic [WORD_W-1:0] acc
  );
    logic [WORD_W-1:0] r;
    r = cur;
    if (op == OP_COPY) begin
      r = acc;
    end else if (op == OP_SET) begin
      r = cur | acc;
    end else if (op == OP_CLR) begin
      r = cur & ~acc;
    end
    return r;
  endfunction

  // Highest pending and enabled level, registered
  plic_prio #(
    .N(WORD_W)
  ) u_prio (
    .pclk(pclk),
    .presetn(presetn),
    .pend(mask_d),
    .top_q(computed_active_level)
  );

  // ****************************************************************
  // Accumulator
  // ****************************************************************
  // Operand for masked and copy operations
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= WORD_ZERO;
    end else if (wr_en && paddr == OFF_ACC) begin
      acc_q <= pwdata[WORD_W-1:0];
    end
  end

  // ****************************************************************
  // Detect bits
  // ****************************************************************
  // Hardware sets win over software clear and give-up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_detect_bits_q <= WORD_ZERO;
    end else begin
      logic [WORD_W-1:0] nxt;
      nxt = level_detect_bits_q;
      if (wr_en && paddr == OFF_OP && !op_tgt) begin
        nxt = apply_op(op_code, nxt, acc_q);
      end
      if (wr_en && paddr == OFF_OP && op_code == OP_GIVEUP) begin
        nxt[current_level_q] = 1'b0;
      end
      for (int i = 0; i < NUM_VEC_LEVELS; i++) begin
        if (vec_req[i]) begin
          nxt[int'(LVL_VEC_LO) + i] = 1'b1;
        end
      end
      if (cause_valid && internal_source_enable_q[cause_code]) begin
        nxt[LVL_INTERNAL] = 1'b1;
      end
      level_detect_bits_q <= nxt;
    end
  end

  // ****************************************************************
  // Enable bits and internal source enable
  // ****************************************************************
  // Masked and copy operations on the enable register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_enable_bits_q <= WORD_ZERO;
    end else if (wr_en && paddr == OFF_OP && op_tgt) begin
      level_enable_bits_q <= apply_op(op_code, level_enable_bits_q,
                                      acc_q);
    end
  end

  // Internal source enable, written directly from the bus write data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      internal_source_enable_q <= 11'h000;
    end else if (wr_en && paddr == OFF_SRC_EN) begin
      internal_source_enable_q <= pwdata[10:0] & IIE_MASK;
    end
  end

  // ****************************************************************
  // Level switching
  // ****************************************************************
  // On and off control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      switching_on_q <= 1'b0;
    end else if (wr_en && paddr == OFF_OP && op_code == OP_ON) begin
      switching_on_q <= 1'b1;
    end else if (wr_en && paddr == OFF_OP && op_code == OP_OFF) begin
      switching_on_q <= 1'b0;
    end
  end

  // Current and previous level, switch pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      current_level_q <= LVL_ZERO;
      previous_level_q <= LVL_ZERO;
      level_switch_q <= 1'b0;
    end else begin
      level_switch_q <= 1'b0;
      if (switching_on_q && computed_active_level != current_level_q) begin
        current_level_q <= computed_active_level;
        previous_level_q <= current_level_q;
        level_switch_q <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Cause code and parity capture
  // ****************************************************************
  // Cause latch, cleared by reading; new cause wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      internal_cause_code_q <= CODE_ZERO;
    end else if (cause_valid && internal_source_enable_q[cause_code]) begin
      internal_cause_code_q <= cause_code;
    end else if (rd_en && paddr == OFF_CAUSE) begin
      internal_cause_code_q <= CODE_ZERO;
    end
  end

  // Parity status and address capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      parity_fault_status_q <= WORD_ZERO;
      parity_fault_address_q <= WORD_ZERO;
    end else if (parity_valid) begin
      parity_fault_status_q <= parity_status;
      parity_fault_address_q <= parity_addr;
    end
  end

  // Lock released once both cause and parity status are read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      locked_q <= 1'b1;
      unlock_seen_q <= 2'b00;
    end else begin
      if (rd_en && paddr == OFF_CAUSE) begin
        unlock_seen_q[0] <= 1'b1;
      end
      if (rd_en && paddr == OFF_PSTAT) begin
        unlock_seen_q[1] <= 1'b1;
      end
      if (&unlock_seen_q) begin
        locked_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Identify search
  // ****************************************************************
  // Request to bus devices and wait for the first answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ident_st_q <= ST_IDLE;
      ident_req_q <= '0;
      ident_code_q <= VEC_ZERO;
      ident_found_q <= 1'b0;
    end else begin
      case (ident_st_q)
        ST_IDLE: begin
          if (wr_en && paddr == OFF_IDENT && pwdata[IDENT_GO_BIT]) begin
            ident_req_q.req <= 1'b1;
            ident_req_q.level <= pwdata[1:0];
            ident_st_q <= ST_ASK;
          end
        end
        ST_ASK: begin
          ident_st_q <= ST_WAIT;
        end
        ST_WAIT: begin
          if (ident_rsp.done) begin
            ident_req_q.req <= 1'b0;
            ident_code_q <= ident_rsp.found ? ident_rsp.code
                                            : VEC_ZERO;
            ident_found_q <= ident_rsp.found;
            ident_st_q <= ST_IDLE;
          end
        end
        default: begin
          ident_st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Interrupt status and mask
  // ****************************************************************
  assign ev_set[EV_SWITCH] = level_switch_q;
  assign ev_set[EV_IDENT] = (ident_st_q == ST_WAIT) && ident_rsp.done;
  assign ev_set[EV_NOANS] = ev_set[EV_IDENT] && !ident_rsp.found;

  // Sticky status, write one to clear, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_q <= '0;
    end else if (wr_en && paddr == OFF_ISTAT) begin
      istat_q <= (istat_q & ~pwdata[EV_W-1:0]) | ev_set;
    end else begin
      istat_q <= istat_q | ev_set;
    end
  end

  // Mask register and registered interrupt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imask_q <= '0;
      irq <= 1'b0;
    end else begin
      if (wr_en && paddr == OFF_IMASK) begin
        imask_q <= pwdata[EV_W-1:0];
      end
      irq <= |(istat_q & imask_q);
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  // Registered read mux; locked registers read as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata_q <= 32'h00000000;
      if (paddr == OFF_DETECT) begin
        prdata_q[WORD_W-1:0] <= level_detect_bits_q;
      end else if (paddr == OFF_ENABLE) begin
        prdata_q[WORD_W-1:0] <= level_enable_bits_q;
      end else if (paddr == OFF_SRC_EN) begin
        prdata_q[10:0] <= internal_source_enable_q;
      end else if (paddr == OFF_CAUSE) begin
        prdata_q[CODE_W-1:0] <= internal_cause_code_q;
      end else if (paddr == OFF_CUR) begin
        prdata_q[LVL_W-1:0] <= current_level_q;
        prdata_q[LVL_W] <= switching_on_q;
      end else if (paddr == OFF_ACTIVE) begin
        prdata_q[LVL_W-1:0] <= computed_active_level;
      end else if (paddr == OFF_PREV) begin
        prdata_q[LVL_W-1:0] <= previous_level_q;
      end else if (paddr == OFF_PSTAT) begin
        prdata_q[WORD_W-1:0] <= locked_q ? WORD_ZERO
                                         : parity_fault_status_q;
      end else if (paddr == OFF_PADDR) begin
        prdata_q[WORD_W-1:0] <= locked_q ? WORD_ZERO
                                         : parity_fault_address_q;
      end else if (paddr == OFF_IDENT) begin
        prdata_q[VEC_W-1:0] <= ident_code_q;
        prdata_q[30] <= ident_found_q;
        prdata_q[IDENT_GO_BIT] <= ident_st_q != ST_IDLE;
      end else if (paddr == OFF_ISTAT) begin
        prdata_q[EV_W-1:0] <= istat_q;
      end else if (paddr == OFF_IMASK) begin
        prdata_q[EV_W-1:0] <= imask_q;
      end else if (paddr == OFF_ACC) begin
        prdata_q[WORD_W-1:0] <= acc_q;
      end
    end
  end

  // Output drives
  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign ident_req = ident_req_q;
  assign current_level = current_level_q;
  assign level_switch = level_switch_q;
endmodule

//--- plic_top_chk.sv
// Purpose: Port-level checks of the program level control
// Assumes: Single clock pclk, reset presetn active low
// Notes: Bound into plic_top below the module
module plic_top_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Sources
  input wire logic [plic_pkg::NUM_VEC_LEVELS-1:0] vec_req,
  input wire logic cause_valid,
  input wire logic [plic_pkg::CODE_W-1:0] cause_code,
  input wire logic parity_valid,
  input wire logic [plic_pkg::WORD_W-1:0] parity_status,
  input wire logic [plic_pkg::WORD_W-1:0] parity_addr,
  // Identify search
  input wire plic_pkg::plic_ident_req_t ident_req,
  input wire plic_pkg::plic_ident_rsp_t ident_rsp,
  // Level state and interrupt
  input wire logic [plic_pkg::LVL_W-1:0] current_level,
  input wire logic level_switch,
  input wire logic irq
);
  import plic_pkg::*;
  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Write that starts a search
  wire logic go_w = psel && penable && pwrite && paddr == OFF_IDENT
    && pwdata[IDENT_GO_BIT];
  // Read access of the cause code
  wire logic rd_c = psel && penable && !pwrite && paddr == OFF_CAUSE;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_no_slverr: assert property (!pslverr)
    else $error("pslverr raised");
  a_switch_moves: assert property (
    level_switch |-> current_level != $past(current_level))
    else $error("switch without level change");
  a_level_frozen: assert property (
    current_level != $past(current_level) |-> level_switch)
    else $error("level changed without switch");
  a_req_starts: assert property (
    go_w && !ident_req.req |=> ident_req.req
      && ident_req.level == $past(pwdata[1:0]))
    else $error("search not started");
  a_req_holds: assert property (
    ident_req.req && !ident_rsp.done |=> ident_req.req)
    else $error("search dropped early");
  a_req_drops: assert property (
    ident_req.req && ident_rsp.done |=> !ident_req.req)
    else $error("search kept after answer");
  a_cause_field: assert property (
    rd_c |-> prdata[31:4] == 28'h0000000)
    else $error("cause upper bits set");
endmodule

bind plic_top plic_top_chk plic_top_chk_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .vec_req(vec_req),
  .cause_valid(cause_valid), .cause_code(cause_code),
  .parity_valid(parity_valid), .parity_status(parity_status),
  .parity_addr(parity_addr), .ident_req(ident_req),
  .ident_rsp(ident_rsp), .current_level(current_level),
  .level_switch(level_switch), .irq(irq));

//--- plic_dev_model.sv
// Purpose: Bus device interfaces answering the identify search
// Assumes: Two slots per level, slot 0 nearest the processor
// Notes: Answer delay set through dly
module plic_dev_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Search request and answer
  input wire plic_pkg::plic_ident_req_t ident_req,
  output plic_pkg::plic_ident_rsp_t ident_rsp,
  // Level requests
  output logic [plic_pkg::NUM_VEC_LEVELS-1:0] vec_req
);
  import plic_pkg::*;
  logic [1:0] pend [4]; // Pending slots per level
  logic [VEC_W-1:0] code [4][2]; // Vector codes
  int dly; // Answer delay in cycles
  int cnt; // Delay countdown
  logic busy; // Search seen
  logic sent; // Answer given
  initial begin
    dly = 0;
    foreach (pend[i]) pend[i] = 2'b00;
  end
  // Posts a request on one slot
  task automatic post(input int l, input int s, input logic [10:0] c);
    code[l][s] = c;
    pend[l][s] = 1'b1;
  endtask
  // Level request while any slot waits
  assign vec_req = {|pend[3], |pend[2], |pend[1], |pend[0]};
  // ****************************************************************
  // Search answer
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
      sent <= 1'b0;
      ident_rsp <= '0;
    end else begin
      ident_rsp.done <= 1'b0;
      // Released lines show no stale code
      if (ident_rsp.done) begin
        ident_rsp.code <= ~ident_rsp.code;
        ident_rsp.found <= 1'b0;
      end
      if (!ident_req.req) begin
        busy <= 1'b0;
        sent <= 1'b0;
      end else if (!busy) begin
        busy <= 1'b1;
        cnt <= dly;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end else if (!sent) begin
        sent <= 1'b1;
        ident_rsp.done <= 1'b1;
        ident_rsp.found <= |pend[ident_req.level];
        // Nearest slot wins and drops its request
        if (pend[ident_req.level][0]) begin
          ident_rsp.code <= code[ident_req.level][0];
          pend[ident_req.level][0] <= 1'b0;
        end else if (pend[ident_req.level][1]) begin
          ident_rsp.code <= code[ident_req.level][1];
          pend[ident_req.level][1] <= 1'b0;
        end else begin
          ident_rsp.code <= VEC_ZERO;
        end
      end
    end
  end
endmodule

//--- tb_program_level_interrupt_control.sv
// Purpose: Self-checking bench of the program level control
// Assumes: 100 MHz pclk, zero wait-state APB
// Notes: Bus devices modelled by plic_dev_model
module tb_program_level_interrupt_control;
  timeunit 1ns;
  timeprecision 1ps;
  import plic_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic cause_valid, parity_valid, level_switch, irq;
  logic [NUM_VEC_LEVELS-1:0] vec_req;
  logic [CODE_W-1:0] cause_code;
  logic [WORD_W-1:0] parity_status, parity_addr;
  logic [LVL_W-1:0] current_level;
  plic_ident_req_t ident_req;
  plic_ident_rsp_t ident_rsp;
  int fails, checked, cycles;
  plic_top plic_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .vec_req(vec_req), .cause_valid(cause_valid),
    .cause_code(cause_code), .parity_valid(parity_valid),
    .parity_status(parity_status), .parity_addr(parity_addr),
    .ident_req(ident_req), .ident_rsp(ident_rsp),
    .current_level(current_level), .level_switch(level_switch),
    .irq(irq));
  plic_dev_model plic_dev_model_inst (.pclk(pclk), .presetn(presetn),
    .ident_req(ident_req), .ident_rsp(ident_rsp), .vec_req(vec_req));
  // Clock and hang guard
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      summarize();
    end
  end
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic summarize();
    if (fails == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // One APB transfer, then one idle edge
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Pins {irq, level_switch, current_level} once settled
  task automatic chk_pin(input logic [31:0] exp);
    @(negedge pclk);
    chk({irq, level_switch, current_level}, exp);
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rv, exp);
  endtask
  task automatic acc_op(input logic [31:0] acc, input logic [31:0] op);
    wr(OFF_ACC, acc);
    wr(OFF_OP, op);
  endtask
  task automatic ident(input logic [1:0] l, input logic [31:0] exp);
    int n;
    n = 0;
    wr(OFF_IDENT, {30'h20000000, l});
    do begin
      apb(1'b0, OFF_IDENT, 32'h0);
      n++;
    end while (rv[31] === 1'b1 && n < 20);
    chk(rv, exp);
  endtask
  task automatic events(input logic [3:0] c, input logic p);
    cause_valid <= !p;
    cause_code <= c;
    parity_valid <= p;
    @(posedge pclk);
    cause_valid <= 1'b0;
    parity_valid <= 1'b0;
    @(posedge pclk);
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_power();
    rd(OFF_SRC_EN, 32'h0);
    rd(OFF_ENABLE, 32'h0);
    rd(OFF_CUR, 32'h0);
    rd(8'h3C, 32'h0);
  endtask
  // Copy, set and clear on both masks
  task automatic t_masks();
    logic [31:0] t;
    logic [7:0] a;
    for (int i = 0; i < 2; i++) begin
      t = i ? 32'h10 : 32'h0;
      a = i ? OFF_ENABLE : OFF_DETECT;
      acc_op(32'h00F0, t | OP_COPY);
      rd(a, 32'h00F0);
      acc_op(32'h0F00, t | OP_SET);
      rd(a, 32'h0FF0);
      acc_op(32'h0330, t | OP_CLR);
      rd(a, 32'h0CC0);
      acc_op(32'hFFFF, t | OP_CLR);
    end
  endtask
  // Level entry, switching on and off, give-up
  task automatic t_levels();
    acc_op(32'h4420, 32'h10 | OP_COPY);
    acc_op(32'h0020, OP_SET);
    rd(OFF_ACTIVE, 32'h5);
    chk_pin(6'h00);
    wr(OFF_OP, OP_ON);
    chk_pin(6'h15);
    rd(OFF_PREV, 32'h0);
    wr(OFF_OP, OP_OFF);
    acc_op(32'h0400, OP_SET);
    rd(OFF_ACTIVE, 32'hA);
    chk_pin(6'h05);
    wr(OFF_OP, OP_ON);
    chk_pin(6'h1A);
    rd(OFF_PREV, 32'h5);
    wr(OFF_OP, OP_GIVEUP);
    rd(OFF_DETECT, 32'h0020);
    chk_pin(6'h05);
    wr(OFF_OP, OP_OFF);
    acc_op(32'hFFFF, OP_CLR);
  endtask
  // Vectored search with interrupt raise, clear and mask
  task automatic t_ident();
    wr(OFF_IMASK, 32'h2);
    plic_dev_model_inst.post(2, 1, 11'h7FF);
    plic_dev_model_inst.post(2, 0, 11'h045);
    @(posedge pclk);
    rd(OFF_DETECT, 32'h1000);
    ident(2'h2, 32'h40000045);
    chk_pin(6'h25);
    wr(OFF_ISTAT, 32'h2);
    chk_pin(6'h05);
    wr(OFF_IMASK, 32'h0);
    plic_dev_model_inst.dly = 5;
    ident(2'h2, 32'h400007FF);
    chk_pin(6'h05);
    ident(2'h2, 32'h0);
    apb(1'b0, OFF_ISTAT, 32'h0);
    chk(rv & 32'h4, 32'h4);
  endtask
  // Cause code read and register unlock
  task automatic t_cause();
    parity_status <= 16'h1234;
    parity_addr <= 16'hBEEF;
    wr(OFF_SRC_EN, 32'h20);
    events(4'h5, 1'b0);
    rd(OFF_CAUSE, 32'h5);
    rd(OFF_CAUSE, 32'h0);
    events(4'h0, 1'b1);
    rd(OFF_PSTAT, 32'h0);
    rd(OFF_PSTAT, 32'h1234);
    rd(OFF_PADDR, 32'hBEEF);
  endtask
  initial begin
    {presetn, psel, penable, pwrite, cause_valid, parity_valid} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cause_code = 4'h0;
    parity_status = 16'h0000;
    parity_addr = 16'h0000;
    fails = 0;
    checked = 0;
    cycles = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_power();
    t_masks();
    t_levels();
    t_ident();
    t_cause();
    summarize();
  end
endmodule
